// file: logic/dtc_pkg.sv
/*
  package for the dual timer/counter pair: register offsets, field positions,
  reset values, mode encodings and machine-cycle timing.
  assumes a 50 MHz ref_clk standing in for the oscillator.
*/
package dtc_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [3:0] DTC_ADR_CTRL = 4'h0;
  localparam logic [3:0] DTC_ADR_MODE = 4'h4;
  localparam logic [3:0] DTC_ADR_LOW_A = 4'h8;
  localparam logic [3:0] DTC_ADR_HIGH_A = 4'hc;
  localparam logic [4:0] DTC_ADR_LOW_B = 5'h10;
  localparam logic [4:0] DTC_ADR_HIGH_B = 5'h14;
  localparam logic [4:0] DTC_ADR_ACK = 5'h18;

  // control register fields
  localparam int DTC_CTL_OVF_B = 7;
  localparam int DTC_CTL_RUN_B = 6;
  localparam int DTC_CTL_OVF_A = 5;
  localparam int DTC_CTL_RUN_A = 4;
  localparam int DTC_CTL_EDGE_B = 3;
  localparam int DTC_CTL_TYPE_B = 2;
  localparam int DTC_CTL_EDGE_A = 1;
  localparam int DTC_CTL_TYPE_A = 0;

  // mode register fields
  localparam int DTC_MOD_GATE_B = 7;
  localparam int DTC_MOD_FUNC_B = 6;
  localparam int DTC_MOD_MODE_B = 4;
  localparam int DTC_MOD_GATE_A = 3;
  localparam int DTC_MOD_FUNC_A = 2;
  localparam int DTC_MOD_MODE_A = 0;

  localparam logic [7:0] DTC_CTRL_RST = 8'h00;
  localparam logic [7:0] DTC_MODE_RST = 8'h00;
  localparam logic [7:0] DTC_BYTE_RST = 8'h00;
  localparam logic [7:0] DTC_BYTE_ONES = 8'hff;
  localparam logic [4:0] DTC_PRE_ONES = 5'h1f;
  localparam logic [7:0] DTC_PRE_MASK = 8'h1f;
  // synchroniser idle levels {irq_b, irq_a, cnt_b, cnt_a}: irq pins idle high
  localparam logic [3:0] DTC_SYNC_RST = 4'hc;
  localparam logic [1:0] DTC_IRQ_IDLE = 2'h3;

  localparam logic [1:0] DTC_MODE_13 = 2'h0;
  localparam logic [1:0] DTC_MODE_16 = 2'h1;
  localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
  localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;

  // machine cycle: 12 oscillator periods
  localparam int DTC_OSC_PER_MC = 12;
  localparam logic [3:0] DTC_MC_LAST = 4'(DTC_OSC_PER_MC - 1);
  localparam logic [3:0] DTC_SAMPLE_PHASE = 4'h9;
endpackage

// file: logic/dtc_timer_pair.sv
/*
  two 8-bit-pair timer/counters with control, mode and count registers over
  classic wishbone (8-bit data in the low byte lane of a 32-bit bus).
  assumes pins are asynchronous to ref_clk; the core pulses ack strobes for one cycle.
*/
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
// Notes on behaviour
// RULE1: timer counts once per machine cycle
// RULE2: counter samples pin, counts high-then-low
// RULE3: edge needs two machine cycles to count
// RULE4: source holds each level one machine cycle
// RULE5: two-bit mode field per timer
// RULE6: mode 0 is 13-bit with 5-bit prescaler
// RULE7: rollover to zero sets overflow flag
// RULE8: count when run and (no gate or pin high)
// RULE9: run bit never clears count bytes
// RULE10: mode 1 is cascaded 16-bit counter
// RULE11: mode 2 reloads low from high
// RULE12: timer b in mode 3 holds
// RULE13: timer a mode 3 splits into two bytes
// RULE14: run bits at control bits 6 and 4
// RULE15: overflow flags bits 5 and 7, ack clears
// RULE16: edge flags bits 3 and 1, ack clears
// RULE17: type bits select falling edge or level
// RULE18: function bit selects machine cycle or pin
// RULE19: reset clears all registers; the pin synchronisers and irq_prev_r load idle levels (irq pins high) instead
// RULE20: ack strobes clear matching flags
`timescale 1ns/1ps
module dtc_timer_pair
  import dtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic ack_ovf_a,
  input wire logic ack_ovf_b,
  input wire logic ack_edge_a,
  input wire logic ack_edge_b,
  output logic ovf_flag_a,
  output logic ovf_flag_b,
  output logic ext_irq_req_a,
  output logic ext_irq_req_b
);
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] count_low_byte_a;
  logic [7:0] count_high_byte_a;
  logic [7:0] count_low_byte_b;
  logic [7:0] count_high_byte_b;
  logic [3:0] phase_r;
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [1:0] cnt_smp_r;
  logic [1:0] cnt_prev_r;
  logic [1:0] cnt_fall_r;
  logic [1:0] irq_prev_r;
  logic mc_tick;
  logic sample_phase;
  logic wr_en;
  logic rd_sel;
  logic [1:0] md_a;
  logic [1:0] md_b;
  logic run_bit_a;
  logic run_bit_b;
  logic en_a;
  logic en_b;
  logic en_ah;
  logic inc_a;
  logic inc_b;
  logic ovf_a;
  logic ovf_b;
  logic ovf_ah;
  logic [1:0] irq_fall;

  assign md_a = mode_r[DTC_MOD_MODE_A +: 2];
  assign md_b = mode_r[DTC_MOD_MODE_B +: 2];
  assign run_bit_a = ctrl_r[DTC_CTL_RUN_A];
  assign run_bit_b = ctrl_r[DTC_CTL_RUN_B];
  assign mc_tick = (phase_r == DTC_MC_LAST);
  assign sample_phase = (phase_r == DTC_SAMPLE_PHASE);
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_sel = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // machine cycle divider
  always_ff @(posedge ref_clk) begin
    if (rst || mc_tick) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 4'h1;
    end
  end

  // pin synchronisers: {irq_b, irq_a, cnt_b, cnt_a}
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // idle levels, so level-type flags do not set falsely after reset
      meta_r <= DTC_SYNC_RST;
      sync_r <= DTC_SYNC_RST;
    end else begin
      meta_r <= {ext_irq_pin_b, ext_irq_pin_a, count_pin_b, count_pin_a};
      sync_r <= meta_r;
    end
  end

  // count pins sampled once per machine cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_smp_r <= 2'h0;
      cnt_prev_r <= 2'h0;
      cnt_fall_r <= 2'h0;
    end else if (sample_phase) begin
      cnt_smp_r <= sync_r[1:0]; // RULE2
      cnt_prev_r <= cnt_smp_r;
      cnt_fall_r <= cnt_prev_r & ~cnt_smp_r; // RULE3
    end else if (mc_tick) begin
      cnt_fall_r <= 2'h0;
    end
  end

  // external interrupt edge detect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_prev_r <= DTC_IRQ_IDLE;
    end else begin
      irq_prev_r <= sync_r[3:2];
    end
  end
  assign irq_fall = irq_prev_r & ~sync_r[3:2];

  // gating and increment selection
  assign en_a = run_bit_a && (!mode_r[DTC_MOD_GATE_A] || sync_r[2]); // RULE8
  assign en_b = run_bit_b && (!mode_r[DTC_MOD_GATE_B] || sync_r[3]) && (md_b != DTC_MODE_SPLIT); // RULE8 RULE12
  assign en_ah = run_bit_b && mc_tick; // RULE13
  // counter increments applied at the end of the machine cycle
  assign inc_a = en_a && mc_tick && (mode_r[DTC_MOD_FUNC_A] ? cnt_fall_r[0] : 1'b1); // RULE1 RULE18
  assign inc_b = en_b && mc_tick && (mode_r[DTC_MOD_FUNC_B] ? cnt_fall_r[1] : 1'b1); // RULE1 RULE18

  always_comb begin
    case (md_a)
      DTC_MODE_13: ovf_a = inc_a && (count_low_byte_a[4:0] == DTC_PRE_ONES) && (count_high_byte_a == DTC_BYTE_ONES);
      DTC_MODE_16: ovf_a = inc_a && (count_low_byte_a == DTC_BYTE_ONES) && (count_high_byte_a == DTC_BYTE_ONES);
      default: ovf_a = inc_a && (count_low_byte_a == DTC_BYTE_ONES);
    endcase
    case (md_b)
      DTC_MODE_13: ovf_b = inc_b && (count_low_byte_b[4:0] == DTC_PRE_ONES) && (count_high_byte_b == DTC_BYTE_ONES);
      DTC_MODE_16: ovf_b = inc_b && (count_low_byte_b == DTC_BYTE_ONES) && (count_high_byte_b == DTC_BYTE_ONES);
      default: ovf_b = inc_b && (count_low_byte_b == DTC_BYTE_ONES);
    endcase
  end
  assign ovf_ah = (md_a == DTC_MODE_SPLIT) && en_ah && (count_high_byte_a == DTC_BYTE_ONES);

  // timer a count bytes; writes never touched by run bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_low_byte_a <= DTC_BYTE_RST; // RULE19
      count_high_byte_a <= DTC_BYTE_RST;
    end else begin
      if (wr_en && wb_adr_i == {1'b0, DTC_ADR_LOW_A}) begin
        count_low_byte_a <= wb_dat_i[7:0]; // RULE9
      end else if (inc_a) begin
        case (md_a)
          DTC_MODE_13: begin
            // prescaler in low five bits; upper bits left as they are
            count_low_byte_a <= (count_low_byte_a & ~DTC_PRE_MASK)
              | ((count_low_byte_a + 8'h01) & DTC_PRE_MASK); // RULE6
          end
          DTC_MODE_RELOAD: count_low_byte_a <= (count_low_byte_a == DTC_BYTE_ONES) ? count_high_byte_a
            : count_low_byte_a + 8'h01; // RULE11
          default: count_low_byte_a <= count_low_byte_a + 8'h01; // RULE10 RULE13
        endcase
      end
      if (wr_en && wb_adr_i == {1'b0, DTC_ADR_HIGH_A}) begin
        count_high_byte_a <= wb_dat_i[7:0];
      end else if (md_a == DTC_MODE_SPLIT) begin
        if (en_ah) begin
          count_high_byte_a <= count_high_byte_a + 8'h01; // RULE13
        end
      end else if (inc_a && md_a == DTC_MODE_13 && count_low_byte_a[4:0] == DTC_PRE_ONES) begin
        count_high_byte_a <= count_high_byte_a + 8'h01; // RULE6
      end else if (inc_a && md_a == DTC_MODE_16 && count_low_byte_a == DTC_BYTE_ONES) begin
        count_high_byte_a <= count_high_byte_a + 8'h01; // RULE10
      end
    end
  end

  // timer b count bytes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_low_byte_b <= DTC_BYTE_RST; // RULE19
      count_high_byte_b <= DTC_BYTE_RST;
    end else begin
      if (wr_en && wb_adr_i == DTC_ADR_LOW_B) begin
        count_low_byte_b <= wb_dat_i[7:0];
      end else if (inc_b) begin
        case (md_b)
          DTC_MODE_13: begin
            count_low_byte_b <= (count_low_byte_b & ~DTC_PRE_MASK)
              | ((count_low_byte_b + 8'h01) & DTC_PRE_MASK); // RULE6
          end
          DTC_MODE_RELOAD: count_low_byte_b <= (count_low_byte_b == DTC_BYTE_ONES) ? count_high_byte_b
            : count_low_byte_b + 8'h01; // RULE11
          default: count_low_byte_b <= count_low_byte_b + 8'h01; // RULE10
        endcase
      end
      if (wr_en && wb_adr_i == DTC_ADR_HIGH_B) begin
        count_high_byte_b <= wb_dat_i[7:0];
      end else if (inc_b && md_b == DTC_MODE_13 && count_low_byte_b[4:0] == DTC_PRE_ONES) begin
        count_high_byte_b <= count_high_byte_b + 8'h01; // RULE6
      end else if (inc_b && md_b == DTC_MODE_16 && count_low_byte_b == DTC_BYTE_ONES) begin
        count_high_byte_b <= count_high_byte_b + 8'h01; // RULE10
      end
    end
  end

  // control register; hardware set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= DTC_CTRL_RST; // RULE19
    end else begin
      if (wr_en && wb_adr_i == {1'b0, DTC_ADR_CTRL}) begin
        ctrl_r <= wb_dat_i[7:0]; // RULE14 RULE17
      end else if (wr_en && wb_adr_i == DTC_ADR_ACK) begin
        // software acknowledge: ones clear the matching flags
        ctrl_r[DTC_CTL_OVF_A] <= ctrl_r[DTC_CTL_OVF_A] & ~wb_dat_i[DTC_CTL_OVF_A];
        ctrl_r[DTC_CTL_OVF_B] <= ctrl_r[DTC_CTL_OVF_B] & ~wb_dat_i[DTC_CTL_OVF_B];
        ctrl_r[DTC_CTL_EDGE_A] <= ctrl_r[DTC_CTL_EDGE_A] & ~wb_dat_i[DTC_CTL_EDGE_A];
        ctrl_r[DTC_CTL_EDGE_B] <= ctrl_r[DTC_CTL_EDGE_B] & ~wb_dat_i[DTC_CTL_EDGE_B];
      end
      if (ack_ovf_a) begin
        ctrl_r[DTC_CTL_OVF_A] <= 1'b0; // RULE15 RULE20
      end
      if (ack_ovf_b) begin
        ctrl_r[DTC_CTL_OVF_B] <= 1'b0; // RULE15 RULE20
      end
      if (ack_edge_a) begin
        ctrl_r[DTC_CTL_EDGE_A] <= 1'b0; // RULE16 RULE20
      end
      if (ack_edge_b) begin
        ctrl_r[DTC_CTL_EDGE_B] <= 1'b0; // RULE16 RULE20
      end
      if (ovf_a) begin
        ctrl_r[DTC_CTL_OVF_A] <= 1'b1; // RULE7
      end
      if (ovf_b || ovf_ah) begin
        ctrl_r[DTC_CTL_OVF_B] <= 1'b1; // RULE7 RULE13
      end
      if (ctrl_r[DTC_CTL_TYPE_A] ? irq_fall[0] : !sync_r[2]) begin
        ctrl_r[DTC_CTL_EDGE_A] <= 1'b1; // RULE16 RULE17
      end
      if (ctrl_r[DTC_CTL_TYPE_B] ? irq_fall[1] : !sync_r[3]) begin
        ctrl_r[DTC_CTL_EDGE_B] <= 1'b1; // RULE16 RULE17
      end
    end
  end

  // mode register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= DTC_MODE_RST; // RULE19
    end else if (wr_en && wb_adr_i == {1'b0, DTC_ADR_MODE}) begin
      mode_r <= wb_dat_i[7:0]; // RULE5
    end
  end

  // wishbone answer: ack one cycle after strobe, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_sel;
      wb_dat_o <= 32'h0000_0000;
      if (rd_sel) begin
        case (wb_adr_i)
          {1'b0, DTC_ADR_CTRL}: wb_dat_o[7:0] <= ctrl_r;
          {1'b0, DTC_ADR_MODE}: wb_dat_o[7:0] <= mode_r;
          {1'b0, DTC_ADR_LOW_A}: wb_dat_o[7:0] <= count_low_byte_a;
          {1'b0, DTC_ADR_HIGH_A}: wb_dat_o[7:0] <= count_high_byte_a;
          DTC_ADR_LOW_B: wb_dat_o[7:0] <= count_low_byte_b;
          DTC_ADR_HIGH_B: wb_dat_o[7:0] <= count_high_byte_b;
          default: wb_dat_o[7:0] <= DTC_BYTE_RST;
        endcase
      end
    end
  end

  assign ovf_flag_a = ctrl_r[DTC_CTL_OVF_A];
  assign ovf_flag_b = ctrl_r[DTC_CTL_OVF_B];
  assign ext_irq_req_a = ctrl_r[DTC_CTL_EDGE_A];
  assign ext_irq_req_b = ctrl_r[DTC_CTL_EDGE_B];

  run_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !run_bit_a && !wr_en |=> $stable(count_low_byte_a)) else $error("timer a moved while stopped"); // RULE8
  mode3_b_a: assert property (@(posedge ref_clk) disable iff (rst)
    md_b == DTC_MODE_SPLIT && !wr_en |=> $stable(count_high_byte_b)) else $error("timer b moved in mode 3"); // RULE12
  ovf_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
    ovf_a |=> ovf_flag_a) else $error("overflow a not flagged"); // RULE7
  ack_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    ack_ovf_a && !ovf_a |=> !ovf_flag_a) else $error("ack did not clear overflow a"); // RULE20
  reload_a: assert property (@(posedge ref_clk) disable iff (rst)
    ovf_a && md_a == DTC_MODE_RELOAD && !wr_en |=> count_low_byte_a == $past(count_high_byte_a))
    else $error("reload value wrong"); // RULE11
  gate_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    mode_r[DTC_MOD_GATE_A] && !sync_r[2] |-> !inc_a) else $error("gated timer counted"); // RULE8
  tick_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
    mc_tick |=> !mc_tick [*8]) else $error("machine cycle too short"); // RULE1
  ctr_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    inc_a && mode_r[DTC_MOD_FUNC_A] |-> cnt_fall_r[0]) else $error("counter moved without edge"); // RULE2
  edge_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_r[DTC_CTL_TYPE_A] && irq_fall[0] |=> ext_irq_req_a) else $error("edge flag a missed"); // RULE16
  cov_ovf_a: cover property (@(posedge ref_clk) ovf_a);
  cov_split_a: cover property (@(posedge ref_clk) ovf_ah);
  cov_count_a: cover property (@(posedge ref_clk) inc_a && mode_r[DTC_MOD_FUNC_A]);
  cov_reload_b: cover property (@(posedge ref_clk) ovf_b && md_b == DTC_MODE_RELOAD);
  cov_level_a: cover property (@(posedge ref_clk) !ctrl_r[DTC_CTL_TYPE_A] && ext_irq_req_a);

  // bus answer timing
  ack_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // timer b and split-mode flags, timer b run hold, split high byte, prescaler and machine cycle length
  ovf_sets_b_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    ovf_b || ovf_ah |=> ovf_flag_b)
    else $error("overflow b not flagged");
  ack_clear_b_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE20
    ack_ovf_b && !ovf_b && !ovf_ah |=> !ovf_flag_b)
    else $error("ack did not clear overflow b");
  run_hold_b_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    !run_bit_b && !wr_en |=> $stable(count_low_byte_b))
    else $error("timer b moved while stopped");
  split_high_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    md_a == DTC_MODE_SPLIT && en_ah && !wr_en |=> count_high_byte_a == $past(count_high_byte_a) + 8'h01)
    else $error("split high byte did not count");
  prescale_top_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
    inc_a && md_a == DTC_MODE_13 && !wr_en |=> $stable(count_low_byte_a[7:5]))
    else $error("prescaler touched upper bits");
  tick_period_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    mc_tick |-> ##12 mc_tick)
    else $error("machine cycle length wrong");

  // interrupt flags
  edge_sets_b_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    ctrl_r[DTC_CTL_TYPE_B] && irq_fall[1] |=> ext_irq_req_b)
    else $error("edge flag b missed");
  level_sets_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE17
    !ctrl_r[DTC_CTL_TYPE_A] && !sync_r[2] |=> ext_irq_req_a)
    else $error("level flag a missed");
  edge_ack_b_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE20
    ack_edge_b && ctrl_r[DTC_CTL_TYPE_B] && !irq_fall[1] |=> !ext_irq_req_b)
    else $error("ack did not clear edge flag b");

  // reset values
  reset_clear_a: assert property (@(posedge ref_clk) // RULE19
    rst |=> ctrl_r == DTC_CTRL_RST && mode_r == DTC_MODE_RST)
    else $error("registers not cleared by reset");
endmodule

// file: dv/dtc_pin_model.sv
/*
  model of the pins outside the timer pair: two count pins and two
  interrupt/gate pins, driven just after rising edges of ref_clk.
  assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps
module dtc_pin_model (
  input wire logic ref_clk,
  output logic count_pin_a,
  output logic count_pin_b,
  output logic ext_irq_pin_a,
  output logic ext_irq_pin_b
);
  initial begin
    count_pin_a = 1'h0;
    count_pin_b = 1'h0;
    ext_irq_pin_a = 1'h1;
    ext_irq_pin_b = 1'h1;
  end

  // n high-then-low pulses, each level held for hold clocks
  task automatic pulse(input bit sel, input int n, input int hold);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge ref_clk);
      if (sel)
        count_pin_b <= ~count_pin_b;
      else
        count_pin_a <= ~count_pin_a;
      repeat (hold - 1) @(posedge ref_clk);
    end
  endtask

  task automatic set_irq(input bit sel, input bit v);
    @(posedge ref_clk);
    if (sel)
      ext_irq_pin_b <= v;
    else
      ext_irq_pin_a <= v;
  endtask
endmodule

// file: dv/testbench.sv
/*
  self-checking bench for the timer pair: reset test, table of mode rows,
  then counter, gate, interrupt flag and byte-lane tests.
  assumes the pin model drives the external pins.
*/
`timescale 1ns/1ps
module testbench;
  import dtc_pkg::*;
  typedef struct {
    logic [7:0] mode, ctrl, la, ha, lb, hb;
    logic [3:0] k;
    logic [7:0] ela, eha, elb, ehb;
    logic [1:0] fl;
  } dtc_row_s;
  logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic count_pin_a, count_pin_b, ext_irq_pin_a, ext_irq_pin_b;
  logic ack_ovf_a, ack_ovf_b, ack_edge_a, ack_edge_b;
  logic ovf_flag_a, ovf_flag_b, ext_irq_req_a, ext_irq_req_b;
  logic [7:0] rd;
  int bad_count, cmp_count;
  dtc_row_s r;
  dtc_row_s rows [6] = '{
    '{8'h11, 8'h55, 8'hfe, 8'hff, 8'h34, 8'h12, 4'h3, 8'h01, 8'h00, 8'h37, 8'h12, 2'h1},
    '{8'h00, 8'h55, 8'hfe, 8'h12, 8'h1e, 8'hff, 4'h3, 8'he1, 8'h13, 8'h01, 8'h00, 2'h2},
    '{8'h22, 8'h55, 8'hfe, 8'h80, 8'h10, 8'h05, 4'h3, 8'h81, 8'h80, 8'h13, 8'h05, 2'h1},
    '{8'h33, 8'h15, 8'hf0, 8'hff, 8'h44, 8'h55, 4'h2, 8'hf2, 8'hff, 8'h44, 8'h55, 2'h0},
    '{8'h33, 8'h45, 8'hf0, 8'hff, 8'h44, 8'h55, 4'h3, 8'hf0, 8'h02, 8'h44, 8'h55, 2'h2},
    '{8'h55, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 4'h3, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0}};

  dtc_timer_pair dtc_timer_pair_i (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .count_pin_a, .count_pin_b, .ext_irq_pin_a, .ext_irq_pin_b,
    .ack_ovf_a, .ack_ovf_b, .ack_edge_a, .ack_edge_b, .ovf_flag_a, .ovf_flag_b, .ext_irq_req_a,
    .ext_irq_req_b);
  dtc_pin_model dtc_pin_model_i (.ref_clk, .count_pin_a, .count_pin_b, .ext_irq_pin_a, .ext_irq_pin_b);

  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {ack_ovf_a, ack_ovf_b, ack_edge_a, ack_edge_b} = 4'h0;
    sel_v = 4'hf;
    wb_sel_i = 4'hf;
    rst = 1'h1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    for (int a = 0; a < 32; a += 4) begin
      wb(1'h0, 5'(a), 8'h00);
      check(rd, 8'h00);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      wb(1'h1, 5'(DTC_ADR_CTRL), 8'h05);
      wb(1'h1, 5'(DTC_ADR_MODE), r.mode);
      wb(1'h1, 5'(DTC_ADR_LOW_A), r.la);
      wb(1'h1, 5'(DTC_ADR_HIGH_A), r.ha);
      wb(1'h1, DTC_ADR_LOW_B, r.lb);
      wb(1'h1, DTC_ADR_HIGH_B, r.hb);
      wb(1'h1, 5'(DTC_ADR_CTRL), r.ctrl);
      repeat (12 * r.k - 6) @(posedge ref_clk);
      check({6'h00, ovf_flag_b, ovf_flag_a}, {6'h00, r.fl});
      ack_ovf_a <= r.fl[0];
      ack_ovf_b <= r.fl[1];
      @(posedge ref_clk);
      ack_ovf_a <= 1'h0;
      ack_ovf_b <= 1'h0;
      repeat (2) @(posedge ref_clk);
      check({6'h00, ovf_flag_b, ovf_flag_a}, 8'h00);
      wb(1'h1, 5'(DTC_ADR_CTRL), 8'h05);
      wb(1'h0, 5'(DTC_ADR_LOW_A), 8'h00);
      check(rd, r.ela);
      wb(1'h0, 5'(DTC_ADR_HIGH_A), 8'h00);
      check(rd, r.eha);
      wb(1'h0, DTC_ADR_LOW_B, 8'h00);
      check(rd, r.elb);
      wb(1'h0, DTC_ADR_HIGH_B, 8'h00);
      check(rd, r.ehb);
      $display("test row %0d done", i);
    end
    wb(1'h1, 5'(DTC_ADR_MODE), 8'h05);
    wb(1'h1, 5'(DTC_ADR_LOW_A), 8'h10);
    wb(1'h1, 5'(DTC_ADR_CTRL), 8'h15);
    dtc_pin_model_i.pulse(1'h0, 4, 12);
    dtc_pin_model_i.pulse(1'h0, 1, 30);
    repeat (48) @(posedge ref_clk);
    wb(1'h0, 5'(DTC_ADR_LOW_A), 8'h00);
    check(rd, 8'h15);
    $display("test counter done");
    dtc_pin_model_i.set_irq(1'h0, 1'h0);
    wb(1'h1, 5'(DTC_ADR_CTRL), 8'h05);
    wb(1'h1, 5'(DTC_ADR_MODE), 8'h09);
    wb(1'h1, 5'(DTC_ADR_LOW_A), 8'h00);
    wb(1'h1, 5'(DTC_ADR_CTRL), 8'h15);
    repeat (60) @(posedge ref_clk);
    wb(1'h0, 5'(DTC_ADR_LOW_A), 8'h00);
    check(rd, 8'h00);
    dtc_pin_model_i.set_irq(1'h0, 1'h1);
    repeat (60) @(posedge ref_clk);
    wb(1'h1, 5'(DTC_ADR_CTRL), 8'h05);
    wb(1'h0, 5'(DTC_ADR_LOW_A), 8'h00);
    check({7'h00, rd !== 8'h00}, 8'h01);
    $display("test gate done");
    dtc_pin_model_i.set_irq(1'h0, 1'h0);
    repeat (6) @(posedge ref_clk);
    check({6'h00, ext_irq_req_b, ext_irq_req_a}, 8'h01);
    ack_edge_a <= 1'h1;
    @(posedge ref_clk);
    ack_edge_a <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check({7'h00, ext_irq_req_a}, 8'h00);
    wb(1'h1, 5'(DTC_ADR_CTRL), 8'h00);
    repeat (6) @(posedge ref_clk);
    check({6'h00, ext_irq_req_b, ext_irq_req_a}, 8'h01);
    $display("test interrupt flags done");
    sel_v = 4'h0;
    wb(1'h1, 5'(DTC_ADR_MODE), 8'hff);
    sel_v = 4'hf;
    wb(1'h1, 5'h1c, 8'hff);
    wb(1'h0, 5'(DTC_ADR_MODE), 8'h00);
    check(rd, 8'h09);
    wb(1'h0, 5'h1c, 8'h00);
    check(rd, 8'h00);
    $display("test byte lanes done");
    report_and_stop();
  end
endmodule
